/* File: design/rsc_defines.vh */
// Constants of the chip reset controller: offsets, fields, reset values and times
`ifndef RSC_DEFINES_VH
`define RSC_DEFINES_VH

`define RSC_OFF_FLAGS 8'h08
`define RSC_OFF_BROWNOUT_DELAY_CONFIG 8'h14
`define RSC_OFF_PERIPH 8'h40

`define RSC_FLAGS_RESET 32'h0000_0001
`define RSC_FLAGS_MASK 32'h0000_00DF
`define RSC_BROWNOUT_DELAY_CONFIG_RESET 32'h0000_0001
`define RSC_BROWNOUT_DELAY_CONFIG_MASK 32'h0000_0001
`define RSC_PERIPH_RESET 32'h0000_0000
`define RSC_PERIPH_MASK 32'h0FFF_FFFE

`define RSC_BIT_FLASH_WRITE_RESET_FLAG 7
`define RSC_BIT_PCOVR 6
`define RSC_BIT_LOCKUP 4
`define RSC_BIT_SWREQ 3
`define RSC_BIT_WDOG 2
`define RSC_BIT_BOR 1
`define RSC_BIT_POR 0
`define RSC_BIT_DLY_SEL 0
`define RSC_BIT_DMA 22

`define RSC_CLK_KHZ 25000
`define RSC_POR_MS 93
`define RSC_RELEASE_MS 7

`define RSC_BOR_D0_42_US 239
`define RSC_BOR_D0_37_US 234
`define RSC_BOR_D0_33_US 199
`define RSC_BOR_D0_28_US 207
`define RSC_BOR_D1_42_US 116
`define RSC_BOR_D1_37_US 112
`define RSC_BOR_D1_33_US 107
`define RSC_BOR_D1_28_US 116

`define RSC_THR_42 3'b001
`define RSC_THR_37 3'b011
`define RSC_THR_33 3'b100
`define RSC_THR_28 3'b101

`define RSC_RESP_OKAY 2'b00
`define RSC_RESP_SLVERR 2'b10

`endif

/* File: design/rsc_delay_count.v */
// Loadable down counter used for the reset release and brown-out filter delays
`timescale 1ns/1ps
module rsc_delay_count #(
  parameter W = 22
) (
  input wire clk_i,
  input wire rst_n_i,
  input wire load_i,
  input wire [W-1:0] value_i,
  output wire zero_o
);
  reg [W-1:0] count_q;
  reg [W-1:0] count_d;

  always @* begin
    count_d = count_q;
    if (load_i) begin
      count_d = value_i;
    end else if (count_q != {W{1'b0}}) begin
      count_d = count_q - {{(W-1){1'b0}}, 1'b1};
    end
  end

  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      count_q <= {W{1'b0}};
    end else begin
      count_q <= count_d;
    end
  end

  assign zero_o = (count_q == {W{1'b0}});
endmodule // rsc_delay_count

/* File: design/rsc_reset_ctrl.v */
// Chip reset controller: reset sequencing, cause flags and peripheral reset holds
`timescale 1ns/1ps
`include "rsc_defines.vh"

// What this block does
// [R01] After power-on, hold the power-on release low for 93 ms, then raise it.
// [R02] After flash programming mode ends, keep system reset low 7 ms more, then release.
// [R03] Watchdog, overflow, software or lockup request pulls system reset low for 7 ms.
// [R04] Once normal operation was reached, flash programming requests are ignored.
// [R05] Brown-out holds system reset while low; release 7 ms after it returns high.
// [R06] Flag bit 7 records flash programming reset, bit 6 program counter overflow reset.
// [R07] Flag bit 4 records lockup, bit 3 software, bit 2 watchdog reset; bit 5 reserved.
// [R08] Flag bit 1 records brown-out reset; bits 31 to 8 read zero.
// [R09] Flag bit 0 records power-on reset and reads 1 after power-on.
// [R10] Writing 0 to a flag bit clears it; nothing else clears flags from software.
// [R11] After power-on the flag register holds only the power-on flag.
// [R12] Brown-out configuration holds one delay select bit, default option 1.
// [R13] Brown-out filter delay follows select and threshold: 199-239 us or 107-116 us.
// [R14] A peripheral hold bit written 1 keeps that module in reset until written 0.
// [R15] Hold bits 27 to 1 map divider, GPIO, DMA, CRC, ADC, watchdog, timers, PWM, I2C, UART, SPI.
// [R16] The DMA hold bit also resets the DMA registers and request multiplexer.
// [R17] Watchdog and overflow requests are sampled each rising edge, then 7 ms reset.
// [R18] System reset stays low while flash programming mode input is high, until normal operation was first reached.
// [R19] Brown-out threshold and enable come from option byte inputs, not registers.
// [R20] Reset flags survive the global resets they record.
// [R21] Any global reset returns hold and brown-out configuration registers to reset values.
module rsc_reset_ctrl #(
  parameter ADDR_W = 8,
  parameter CNT_W = 22,
  parameter POR_CYCLES = `RSC_POR_MS * `RSC_CLK_KHZ,
  parameter RELEASE_CYCLES = `RSC_RELEASE_MS * `RSC_CLK_KHZ,
  parameter CYC_PER_US = `RSC_CLK_KHZ / 1000
) (
  input wire ref_clk_i,
  input wire rst_b_i,
  input wire flash_program_mode_i,
  input wire brownout_detect_n_i,
  input wire brownout_enable_i,
  input wire [2:0] brownout_threshold_choice_i,
  input wire watchdog_overflow_i,
  input wire pc_overrun_i,
  input wire cpu_reset_request_i,
  input wire cpu_lockup_i,
  output reg power_on_release_n_o,
  output reg sys_reset_n_o,
  output reg [26:0] peripheral_reset_hold_o,
  output reg transfer_mux_reset_o,
  input wire [ADDR_W-1:0] s_axil_awaddr,
  input wire s_axil_awvalid,
  output reg s_axil_awready,
  input wire [31:0] s_axil_wdata,
  input wire [3:0] s_axil_wstrb,
  input wire s_axil_wvalid,
  output reg s_axil_wready,
  output reg [1:0] s_axil_bresp,
  output reg s_axil_bvalid,
  input wire s_axil_bready,
  input wire [ADDR_W-1:0] s_axil_araddr,
  input wire s_axil_arvalid,
  output reg s_axil_arready,
  output reg [31:0] s_axil_rdata,
  output reg [1:0] s_axil_rresp,
  output reg s_axil_rvalid,
  input wire s_axil_rready
);
  localparam [2:0] ST_INIT = 3'd0;
  localparam [2:0] ST_POR = 3'd1;
  localparam [2:0] ST_HOLD = 3'd2;
  localparam [2:0] ST_DELAY = 3'd3;
  localparam [2:0] ST_RUN = 3'd4;

  // Filter delay in microseconds for the delay option and threshold code
  function [31:0] bor_delay_us;
    input sel;
    input [2:0] thr;
    begin
      case (thr)
        `RSC_THR_37: bor_delay_us = sel ? `RSC_BOR_D1_37_US : `RSC_BOR_D0_37_US;
        `RSC_THR_33: bor_delay_us = sel ? `RSC_BOR_D1_33_US : `RSC_BOR_D0_33_US;
        `RSC_THR_28: bor_delay_us = sel ? `RSC_BOR_D1_28_US : `RSC_BOR_D0_28_US;
        default: bor_delay_us = sel ? `RSC_BOR_D1_42_US : `RSC_BOR_D0_42_US;
      endcase
    end
  endfunction

  // Merge written bytes into an old value by strobe
  function [31:0] merge_strb;
    input [31:0] old_v;
    input [31:0] new_v;
    input [3:0] strb;
    integer i;
    begin
      merge_strb = old_v;
      for (i = 0; i < 4; i = i + 1) begin
        if (strb[i]) begin
          merge_strb[i*8 +: 8] = new_v[i*8 +: 8];
        end
      end
    end
  endfunction

  reg rst_meta_q;
  reg rst_sync_q;
  reg [2:0] state_q;
  reg [2:0] state_d;
  reg run_seen_q;
  reg [31:0] flags_q;
  reg [31:0] flags_d;
  reg [31:0] flag_set;
  reg [31:0] brownout_delay_config_q;
  reg [31:0] brownout_delay_config_d;
  reg [31:0] periph_q;
  reg [31:0] periph_d;
  reg seq_load;
  reg [CNT_W-1:0] seq_value;
  reg sys_reset_n_d;
  reg por_rel_d;
  reg [ADDR_W-1:0] aw_addr_q;
  reg [31:0] w_data_q;
  reg [3:0] w_strb_q;
  reg aw_got_q;
  reg w_got_q;
  reg [31:0] rd_value;
  reg rd_hit;
  wire seq_zero;
  wire bor_zero;
  wire bor_low;
  wire bor_active;
  wire flash_write_reset_flag_req;
  wire any_event;
  wire do_write;
  wire wr_hit;
  wire [31:0] wr_merged_flags;
  wire [31:0] wr_merged_cfg;
  wire [31:0] wr_merged_periph;
  wire [31:0] bor_cycles;

  // Reset release through two flip-flops
  always @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end

  rsc_delay_count #(.W(CNT_W)) u_seq_count (
    .clk_i(ref_clk_i),
    .rst_n_i(rst_sync_q),
    .load_i(seq_load),
    .value_i(seq_value),
    .zero_o(seq_zero)
  );

  // Brown-out filter: low level must last the selected delay before it counts
  assign bor_cycles = bor_delay_us(brownout_delay_config_q[`RSC_BIT_DLY_SEL], brownout_threshold_choice_i) * CYC_PER_US; // [R13]
  assign bor_low = brownout_enable_i & ~brownout_detect_n_i; // [R19]

  rsc_delay_count #(.W(CNT_W)) u_bor_filter (
    .clk_i(ref_clk_i),
    .rst_n_i(rst_sync_q),
    .load_i(~bor_low),
    .value_i(bor_cycles[CNT_W-1:0]),
    .zero_o(bor_zero)
  );

  assign bor_active = bor_low & bor_zero; // [R05]
  assign flash_write_reset_flag_req = flash_program_mode_i & ~run_seen_q; // [R04]
  assign any_event = watchdog_overflow_i | pc_overrun_i | cpu_reset_request_i | cpu_lockup_i; // [R03] [R17]

  // Reset sequencer
  always @* begin
    state_d = state_q;
    seq_load = 1'b0;
    seq_value = RELEASE_CYCLES[CNT_W-1:0];
    sys_reset_n_d = sys_reset_n_o;
    por_rel_d = power_on_release_n_o;
    flag_set = 32'h0000_0000;
    case (state_q)
      ST_INIT: begin
        seq_load = 1'b1;
        seq_value = POR_CYCLES[CNT_W-1:0];
        state_d = ST_POR;
      end
      ST_POR: begin
        if (seq_zero) begin
          por_rel_d = 1'b1; // [R01]
          state_d = ST_HOLD;
        end
      end
      ST_HOLD: begin
        if (!(flash_write_reset_flag_req | bor_active)) begin
          seq_load = 1'b1; // [R02] [R05]
          state_d = ST_DELAY;
        end
      end
      ST_DELAY: begin
        if (flash_write_reset_flag_req | bor_active) begin
          state_d = ST_HOLD; // [R18]
        end else if (seq_zero) begin
          sys_reset_n_d = 1'b1; // [R02] [R03]
          state_d = ST_RUN;
        end
      end
      ST_RUN: begin
        if (bor_active) begin
          sys_reset_n_d = 1'b0; // [R05]
          state_d = ST_HOLD;
        end else if (any_event) begin
          sys_reset_n_d = 1'b0; // [R03] [R17]
          seq_load = 1'b1;
          state_d = ST_DELAY;
          flag_set[`RSC_BIT_WDOG] = watchdog_overflow_i; // [R07]
          flag_set[`RSC_BIT_PCOVR] = pc_overrun_i; // [R06]
          flag_set[`RSC_BIT_SWREQ] = cpu_reset_request_i; // [R07]
          flag_set[`RSC_BIT_LOCKUP] = cpu_lockup_i; // [R07]
        end
      end
      default: begin
        state_d = ST_INIT;
      end
    endcase
    if (state_q != ST_INIT && state_q != ST_POR) begin
      flag_set[`RSC_BIT_BOR] = flag_set[`RSC_BIT_BOR] | bor_active; // [R08]
      flag_set[`RSC_BIT_FLASH_WRITE_RESET_FLAG] = flash_write_reset_flag_req; // [R06]
    end
  end

  always @(posedge ref_clk_i or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      state_q <= ST_INIT;
      run_seen_q <= 1'b0;
      sys_reset_n_o <= 1'b0;
      power_on_release_n_o <= 1'b0;
    end else begin
      state_q <= state_d;
      sys_reset_n_o <= sys_reset_n_d;
      power_on_release_n_o <= por_rel_d;
      if (state_d == ST_RUN) begin
        run_seen_q <= 1'b1; // [R04]
      end
    end
  end

  // Register bus: address and data taken in either order, write done when both held
  assign do_write = aw_got_q & w_got_q & ~s_axil_bvalid;
  assign wr_hit = (aw_addr_q == `RSC_OFF_FLAGS) | (aw_addr_q == `RSC_OFF_BROWNOUT_DELAY_CONFIG) |
                  (aw_addr_q == `RSC_OFF_PERIPH);
  assign wr_merged_flags = merge_strb(flags_q, w_data_q, w_strb_q);
  assign wr_merged_cfg = merge_strb(brownout_delay_config_q, w_data_q, w_strb_q);
  assign wr_merged_periph = merge_strb(periph_q, w_data_q, w_strb_q);

  always @* begin
    flags_d = flags_q;
    if (do_write && aw_addr_q == `RSC_OFF_FLAGS) begin
      flags_d = flags_q & wr_merged_flags; // [R10]
    end
    flags_d = (flags_d | flag_set) & `RSC_FLAGS_MASK; // [R06] [R07] [R08]
    brownout_delay_config_d = brownout_delay_config_q;
    periph_d = periph_q;
    if (do_write && aw_addr_q == `RSC_OFF_BROWNOUT_DELAY_CONFIG) begin
      brownout_delay_config_d = wr_merged_cfg & `RSC_BROWNOUT_DELAY_CONFIG_MASK; // [R12]
    end
    if (do_write && aw_addr_q == `RSC_OFF_PERIPH) begin
      periph_d = wr_merged_periph & `RSC_PERIPH_MASK; // [R14] [R15]
    end
    if (!sys_reset_n_o) begin
      brownout_delay_config_d = `RSC_BROWNOUT_DELAY_CONFIG_RESET; // [R21]
      periph_d = `RSC_PERIPH_RESET; // [R21]
    end
  end

  // Flags are cleared only by the power-on reset and by software writes of 0
  always @(posedge ref_clk_i or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      flags_q <= `RSC_FLAGS_RESET; // [R09] [R11]
    end else begin
      flags_q <= flags_d; // [R20]
    end
  end

  always @(posedge ref_clk_i or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      brownout_delay_config_q <= `RSC_BROWNOUT_DELAY_CONFIG_RESET; // [R12]
      periph_q <= `RSC_PERIPH_RESET; // [R14]
      peripheral_reset_hold_o <= 27'd0;
      transfer_mux_reset_o <= 1'b0;
    end else begin
      brownout_delay_config_q <= brownout_delay_config_d;
      periph_q <= periph_d;
      peripheral_reset_hold_o <= periph_d[27:1]; // [R14] [R15]
      transfer_mux_reset_o <= periph_d[`RSC_BIT_DMA]; // [R16]
    end
  end

  always @(posedge ref_clk_i or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      s_axil_awready <= 1'b1;
      s_axil_wready <= 1'b1;
      s_axil_bvalid <= 1'b0;
      s_axil_bresp <= `RSC_RESP_OKAY;
      aw_got_q <= 1'b0;
      w_got_q <= 1'b0;
      aw_addr_q <= {ADDR_W{1'b0}};
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
    end else begin
      if (s_axil_awvalid && s_axil_awready) begin
        aw_addr_q <= s_axil_awaddr;
        aw_got_q <= 1'b1;
        s_axil_awready <= 1'b0;
      end
      if (s_axil_wvalid && s_axil_wready) begin
        w_data_q <= s_axil_wdata;
        w_strb_q <= s_axil_wstrb;
        w_got_q <= 1'b1;
        s_axil_wready <= 1'b0;
      end
      if (do_write) begin
        s_axil_bvalid <= 1'b1;
        s_axil_bresp <= wr_hit ? `RSC_RESP_OKAY : `RSC_RESP_SLVERR;
      end
      if (s_axil_bvalid && s_axil_bready) begin
        s_axil_bvalid <= 1'b0;
        aw_got_q <= 1'b0;
        w_got_q <= 1'b0;
        s_axil_awready <= 1'b1;
        s_axil_wready <= 1'b1;
      end
    end
  end

  always @* begin
    rd_hit = 1'b1;
    case (s_axil_araddr)
      `RSC_OFF_FLAGS: rd_value = flags_q;
      `RSC_OFF_BROWNOUT_DELAY_CONFIG: rd_value = brownout_delay_config_q;
      `RSC_OFF_PERIPH: rd_value = periph_q;
      default: begin
        rd_value = 32'h0000_0000;
        rd_hit = 1'b0;
      end
    endcase
  end

  always @(posedge ref_clk_i or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      s_axil_arready <= 1'b1;
      s_axil_rvalid <= 1'b0;
      s_axil_rdata <= 32'h0000_0000;
      s_axil_rresp <= `RSC_RESP_OKAY;
    end else begin
      if (s_axil_arvalid && s_axil_arready) begin
        s_axil_arready <= 1'b0;
        s_axil_rvalid <= 1'b1;
        s_axil_rdata <= rd_value;
        s_axil_rresp <= rd_hit ? `RSC_RESP_OKAY : `RSC_RESP_SLVERR;
      end
      if (s_axil_rvalid && s_axil_rready) begin
        s_axil_rvalid <= 1'b0;
        s_axil_arready <= 1'b1;
      end
    end
  end
endmodule // rsc_reset_ctrl

/* File: verification/rsc_reset_ctrl_chk.sv */
// Assertion checker for the chip reset controller ports
`timescale 1ns/1ps
module rsc_reset_ctrl_chk #(
  parameter POR_CYCLES = 50,
  parameter RELEASE_CYCLES = 20,
  parameter CYC_PER_US = 1
) (
  input logic ref_clk_i,
  input logic rst_b_i,
  input logic flash_program_mode_i,
  input logic brownout_detect_n_i,
  input logic brownout_enable_i,
  input logic watchdog_overflow_i,
  input logic pc_overrun_i,
  input logic cpu_reset_request_i,
  input logic cpu_lockup_i,
  input logic power_on_release_n_o,
  input logic sys_reset_n_o,
  input logic [26:0] peripheral_reset_hold_o,
  input logic transfer_mux_reset_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_b_i);
  int por_cnt;
  int lo_cnt;
  int bh_cnt;
  int bl_cnt;
  logic ran_q;
  logic any_req;
  assign any_req = watchdog_overflow_i | pc_overrun_i | cpu_reset_request_i | cpu_lockup_i;
  // Cycle counters since reset, of reset low, and of brown-out high and low
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      por_cnt <= 0;
      lo_cnt <= 0;
      bh_cnt <= 0;
      bl_cnt <= 0;
      ran_q <= 1'b0;
    end else begin
      por_cnt <= por_cnt + 1;
      lo_cnt <= sys_reset_n_o ? 0 : lo_cnt + 1;
      bh_cnt <= brownout_detect_n_i ? bh_cnt + 1 : 0;
      bl_cnt <= brownout_detect_n_i ? 0 : bl_cnt + 1;
      ran_q <= ran_q | sys_reset_n_o;
    end
  end
  sequence s_run_req;
    any_req && sys_reset_n_o;
  endsequence
  sequence s_glob;
    !sys_reset_n_o ##1 !sys_reset_n_o;
  endsequence
  property p_por; $rose(power_on_release_n_o) |-> por_cnt >= POR_CYCLES && por_cnt <= POR_CYCLES + 5; endproperty
  a_por: assert property (p_por) else $error("power-on release at wrong time");
  property p_req_drop; s_run_req |=> !sys_reset_n_o; endproperty
  a_req_drop: assert property (p_req_drop) else $error("request did not pull reset low");
  property p_hold_min; $rose(sys_reset_n_o) |-> lo_cnt >= RELEASE_CYCLES; endproperty
  a_hold_min: assert property (p_hold_min) else $error("reset released too early");
  property p_bo_rel; $rose(sys_reset_n_o) |-> bh_cnt >= RELEASE_CYCLES; endproperty
  a_bo_rel: assert property (p_bo_rel) else $error("reset released too soon after brown-out");
  // Longest filter delay is 239 us, reset must be low one microsecond (CYC_PER_US cycles) later
  property p_bo_drop; bl_cnt == 240 * CYC_PER_US && brownout_enable_i && power_on_release_n_o |-> !sys_reset_n_o; endproperty
  a_bo_drop: assert property (p_bo_drop) else $error("brown-out did not reset");
  property p_bo_off; sys_reset_n_o && !brownout_enable_i && !any_req |=> sys_reset_n_o; endproperty
  a_bo_off: assert property (p_bo_off) else $error("disabled brown-out caused reset");
  property p_flash_write_reset_flag_hold; !ran_q && !sys_reset_n_o && flash_program_mode_i |=> !sys_reset_n_o; endproperty
  a_flash_write_reset_flag_hold: assert property (p_flash_write_reset_flag_hold) else $error("programming mode did not hold reset");
  property p_flash_write_reset_flag_ign;
    ran_q && sys_reset_n_o && flash_program_mode_i && !any_req && brownout_detect_n_i && bl_cnt == 0 |=> sys_reset_n_o;
  endproperty
  a_flash_write_reset_flag_ign: assert property (p_flash_write_reset_flag_ign) else $error("programming request not ignored");
  property p_glob_clr; s_glob |-> peripheral_reset_hold_o == 27'h000_0000 && !transfer_mux_reset_o; endproperty
  a_glob_clr: assert property (p_glob_clr) else $error("holds not cleared by global reset");
  property p_dma; $rose(peripheral_reset_hold_o[21]) |-> ##[0:1] transfer_mux_reset_o; endproperty
  a_dma: assert property (p_dma) else $error("transfer reset does not follow hold bit");
endmodule // rsc_reset_ctrl_chk

/* File: verification/rsc_src_model.sv */
// Model of the reset sources around the reset controller
`timescale 1ns/1ps
module rsc_src_model (
  input wire ref_clk_i,
  output logic [3:0] req_o,
  output logic brownout_detect_n_o,
  output logic flash_program_mode_o
);
  initial begin
    req_o = 4'h0;
    brownout_detect_n_o = 1'b1;
    flash_program_mode_o = 1'b0;
  end
  // One-cycle request: 0 watchdog, 1 pc overrun, 2 software, 3 lockup
  task automatic pulse(input int k);
    @(posedge ref_clk_i);
    req_o <= 4'h1 << k;
    @(posedge ref_clk_i);
    req_o <= 4'h0;
  endtask
  task automatic set_bo(input logic v);
    @(posedge ref_clk_i);
    brownout_detect_n_o <= v;
  endtask
  task automatic set_flash_write_reset_flag(input logic v);
    @(posedge ref_clk_i);
    flash_program_mode_o <= v;
  endtask
endmodule // rsc_src_model

/* File: verification/test_chip_reset_controller.sv */
// Testbench of the chip reset controller
`timescale 1ns/1ps
`include "rsc_defines.vh"
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin failures++; $display("BAD t=%0t got %h exp %h", $time, a, b); end end
module test_chip_reset_controller;
  localparam int PC = 50;
  localparam int RC = 20;
  localparam logic [7:0] FL = `RSC_OFF_FLAGS;
  localparam logic [7:0] BC = `RSC_OFF_BROWNOUT_DELAY_CONFIG;
  localparam logic [7:0] PH = `RSC_OFF_PERIPH;
  logic ref_clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic brownout_enable_i = 1'b1;
  logic [2:0] brownout_threshold_choice_i = 3'b100;
  wire [3:0] req;
  wire flash_program_mode_i;
  wire brownout_detect_n_i;
  wire power_on_release_n_o, sys_reset_n_o, transfer_mux_reset_o;
  wire [26:0] peripheral_reset_hold_o;
  logic [7:0] s_axil_awaddr = '0, s_axil_araddr = '0;
  logic [31:0] s_axil_wdata = '0;
  logic [3:0] s_axil_wstrb = '0;
  logic s_axil_awvalid = 0, s_axil_wvalid = 0, s_axil_bready = 0, s_axil_arvalid = 0, s_axil_rready = 0;
  wire s_axil_awready, s_axil_wready, s_axil_bvalid, s_axil_arready, s_axil_rvalid;
  wire [1:0] s_axil_bresp, s_axil_rresp;
  wire [31:0] s_axil_rdata;
  int failures = 0;
  int n_tests = 0;
  int n;
  int fb [4] = '{2, 6, 3, 4};
  int dly [2] = '{`RSC_BOR_D1_28_US, `RSC_BOR_D0_33_US};
  logic [2:0] thr [2] = '{`RSC_THR_28, `RSC_THR_33};
  logic [31:0] d;
  logic [1:0] r;
  rsc_src_model i_src (.ref_clk_i, .req_o(req), .brownout_detect_n_o(brownout_detect_n_i),
    .flash_program_mode_o(flash_program_mode_i));
  rsc_reset_ctrl #(.POR_CYCLES(PC), .RELEASE_CYCLES(RC), .CYC_PER_US(1)) i_dut (.ref_clk_i, .rst_b_i,
    .flash_program_mode_i, .brownout_detect_n_i, .brownout_enable_i, .brownout_threshold_choice_i,
    .watchdog_overflow_i(req[0]), .pc_overrun_i(req[1]), .cpu_reset_request_i(req[2]), .cpu_lockup_i(req[3]),
    .power_on_release_n_o, .sys_reset_n_o, .peripheral_reset_hold_o, .transfer_mux_reset_o,
    .s_axil_awaddr, .s_axil_awvalid, .s_axil_awready, .s_axil_wdata, .s_axil_wstrb, .s_axil_wvalid,
    .s_axil_wready, .s_axil_bresp, .s_axil_bvalid, .s_axil_bready, .s_axil_araddr, .s_axil_arvalid,
    .s_axil_arready, .s_axil_rdata, .s_axil_rresp, .s_axil_rvalid, .s_axil_rready);
  initial begin
    forever #20 ref_clk_i = ~ref_clk_i;
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [3:0] s);
    @(posedge ref_clk_i);
    s_axil_awaddr <= a;
    s_axil_wdata <= v;
    s_axil_wstrb <= s;
    s_axil_awvalid <= 1'b1;
    s_axil_wvalid <= 1'b1;
    s_axil_bready <= 1'b1;
    do begin
      @(posedge ref_clk_i);
      if (s_axil_awready) s_axil_awvalid <= 1'b0;
      if (s_axil_wready) s_axil_wvalid <= 1'b0;
    end while (s_axil_bvalid !== 1'b1);
    s_axil_bready <= 1'b0;
    `CHK(s_axil_bresp, `RSC_RESP_OKAY)
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] e);
    @(posedge ref_clk_i);
    s_axil_araddr <= a;
    s_axil_arvalid <= 1'b1;
    s_axil_rready <= 1'b1;
    do begin
      @(posedge ref_clk_i);
      if (s_axil_arready) s_axil_arvalid <= 1'b0;
    end while (s_axil_rvalid !== 1'b1);
    s_axil_rready <= 1'b0;
    v = s_axil_rdata;
    e = s_axil_rresp;
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    rd(a, d, r);
    `CHK(d, e)
  endtask
  task automatic wait_sys(input logic lvl);
    n = 0;
    while (sys_reset_n_o !== lvl) begin
      @(posedge ref_clk_i);
      n++;
    end
  endtask
  task close_out;
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    #400_000;
    failures++;
    close_out;
  end
  initial begin
    repeat (20) @(posedge ref_clk_i);
    rst_b_i <= 1'b1;
    wait_sys(1'b1);
    `CHK(power_on_release_n_o, 1'b1)
    rc(FL, 32'h0000_0001);
    rc(BC, 32'h0000_0001);
    rc(PH, 32'h0000_0000);
    rd(8'h00, d, r);
    `CHK(r, `RSC_RESP_SLVERR)
    `CHK(d, 32'h0000_0000)
    wr(FL, 32'hFFFF_FFFF, 4'hF);
    rc(FL, 32'h0000_0001);
    wr(FL, 32'h0000_0000, 4'h0);
    rc(FL, 32'h0000_0001);
    wr(FL, 32'h0000_0000, 4'hF);
    rc(FL, 32'h0000_0000);
    $display("test reset values and flag clear done");
    wr(PH, 32'hFFFF_FFFF, 4'hF);
    rc(PH, 32'h0FFF_FFFE);
    @(negedge ref_clk_i);
    `CHK(peripheral_reset_hold_o, 27'h7FF_FFFF)
    wr(PH, 32'h0040_0000, 4'hF);
    @(negedge ref_clk_i);
    `CHK(peripheral_reset_hold_o, 27'h020_0000)
    `CHK(transfer_mux_reset_o, 1'b1)
    wr(BC, 32'h0000_0000, 4'hF);
    rc(BC, 32'h0000_0000);
    $display("test peripheral holds done");
    for (int k = 0; k < 4; k++) begin
      i_src.pulse(k);
      wait_sys(1'b0);
      `CHK(n, 1)
      wait_sys(1'b1);
      `CHK(n >= RC && n <= RC + 4, 1'b1)
      rc(FL, 32'h1 << fb[k]);
      rc(PH, 32'h0000_0000);
      rc(BC, 32'h0000_0001);
      wr(FL, 32'h0000_0000, 4'hF);
    end
    $display("test reset requests done");
    i_src.set_bo(1'b0);
    repeat (50) @(posedge ref_clk_i);
    i_src.set_bo(1'b1);
    `CHK(sys_reset_n_o, 1'b1)
    for (int s = 0; s < 2; s++) begin
      wr(BC, {31'h0, s == 0}, 4'hF);
      brownout_threshold_choice_i <= thr[s];
      i_src.set_bo(1'b0);
      wait_sys(1'b0);
      `CHK(n >= dly[s] && n <= dly[s] + 4, 1'b1)
      repeat (50) @(posedge ref_clk_i);
      `CHK(sys_reset_n_o, 1'b0)
      i_src.set_bo(1'b1);
      wait_sys(1'b1);
      `CHK(n >= RC && n <= RC + 4, 1'b1)
      rc(FL, 32'h0000_0002);
      wr(FL, 32'h0000_0000, 4'hF);
    end
    $display("test brown-out done");
    @(posedge ref_clk_i);
    brownout_enable_i <= 1'b0;
    i_src.set_bo(1'b0);
    repeat (250) @(posedge ref_clk_i);
    `CHK(sys_reset_n_o, 1'b1)
    i_src.set_bo(1'b1);
    brownout_enable_i <= 1'b1;
    $display("test brown-out disable done");
    i_src.set_flash_write_reset_flag(1'b1);
    repeat (40) @(posedge ref_clk_i);
    `CHK(sys_reset_n_o, 1'b1)
    rc(FL, 32'h0000_0000);
    rst_b_i <= 1'b0;
    repeat (3) @(posedge ref_clk_i);
    `CHK(power_on_release_n_o, 1'b0)
    rst_b_i <= 1'b1;
    repeat (PC + 40) @(posedge ref_clk_i);
    `CHK(sys_reset_n_o, 1'b0)
    i_src.set_flash_write_reset_flag(1'b0);
    wait_sys(1'b1);
    `CHK(n >= RC && n <= RC + 4, 1'b1)
    rc(FL, 32'h0000_0081);
    $display("test programming mode done");
    close_out;
  end
endmodule // test_chip_reset_controller
bind rsc_reset_ctrl rsc_reset_ctrl_chk #(.POR_CYCLES(POR_CYCLES), .RELEASE_CYCLES(RELEASE_CYCLES),
  .CYC_PER_US(CYC_PER_US)) i_chk (
  .ref_clk_i, .rst_b_i, .flash_program_mode_i, .brownout_detect_n_i, .brownout_enable_i,
  .watchdog_overflow_i, .pc_overrun_i, .cpu_reset_request_i, .cpu_lockup_i, .power_on_release_n_o,
  .sys_reset_n_o, .peripheral_reset_hold_o, .transfer_mux_reset_o);
